/* logic/tdm_pkg.sv */
// Shared constants and carrier types of the stream timing front end
package tdm_pkg;
  localparam int STREAMS = 16;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RESET_MIN_NS = 100;
  localparam int RESET_CYCLES_I = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [4:0] RESET_CYCLES = 5'(RESET_CYCLES_I);
  localparam logic [1:0] RATE_2M = 2'h0;
  localparam logic [1:0] RATE_4M = 2'h1;
  localparam logic [1:0] RATE_8M = 2'h2;
  localparam logic [6:0] LAST_CH_2M = 7'h1f;
  localparam logic [6:0] LAST_CH_4M = 7'h3f;
  localparam logic [6:0] LAST_CH_8M = 7'h7f;
  localparam logic [2:0] IDLE_RUN = 3'h4;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0] LAST_STREAM = 4'hf;
  localparam logic [7:0] MEAS_MAX = 8'hff;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [2:0] {
    FMT_UNKNOWN = 3'h1,
    FMT_STD = 3'h2,
    FMT_GCI = 3'h4
  } fmt_t;
  typedef struct packed {
    logic par;
    logic [3:0] stream;
    logic [6:0] channel;
    logic [7:0] data;
  } byte_wr_t;
  typedef struct packed {
    logic valid;
    logic [3:0] stream;
    logic [7:0] half_bits;
  } offset_t;
endpackage

/* logic/tdm_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module tdm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready_out = cnt_r != (AW+1)'(DEPTH);
  assign out_valid_out = cnt_r != '0;
  assign out_data_out = mem[rp_r];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wp_r] <= in_data_in;
    end
  end
endmodule

/* logic/tdm_stream_frame_timing.sv */
// Serial stream interface, frame timing and switching core of the time-slot switch
`timescale 1ns/100ps
// What this block does
// - Every output channel can take any input channel of the previous frame, 2048, 1024 or 512 channels at the three rates.
// - Sixteen three-state serial outputs run at the rate picked by the two-bit rate field.
// - Sixteen serial inputs are sampled at that same rate, which the sources must also use.
// - With wide frame select low the frame pulse polarity is found automatically, standard or GCI.
// - With wide frame select high the frame pulse is a negative wide pulse driven by the outside system.
// - The input frame offset is measured one selected stream at a time through the evaluation input.
// - Test data out changes only on a falling test clock edge.
// - Test data out floats whenever scan is not enabled.
// - Reset pin low for at least 100 ns clears the bit and channel counters, the format and the offset result, and floats the serial outputs.
module tdm_stream_frame_timing (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic reset_n_in,
  input wire logic [1:0] rate_field_in,
  input wire logic wide_frame_select_in,
  input wire logic serial_clock_in,
  input wire logic frame_pulse_in,
  input wire logic frame_eval_or_helper_clock_in,
  input wire logic [15:0] serial_in_streams_in,
  output logic [15:0] serial_out_streams_out,
  output logic [15:0] serial_out_oe_out,
  input wire logic conn_wr_in,
  input wire logic [10:0] conn_addr_in,
  input wire logic [10:0] conn_src_in,
  input wire logic [3:0] eval_stream_in,
  output tdm_pkg::offset_t offset_out,
  output tdm_pkg::fmt_t frame_format_out,
  output logic frame_start_out,
  input wire logic test_clock_in,
  input wire logic test_data_in,
  input wire logic scan_enable_in,
  output logic test_data_out,
  output logic test_data_oe_out
);
  function automatic logic [6:0] last_chan(input logic [1:0] rate);
    case (rate)
      tdm_pkg::RATE_4M: last_chan = tdm_pkg::LAST_CH_4M;
      tdm_pkg::RATE_8M: last_chan = tdm_pkg::LAST_CH_8M;
      default: last_chan = tdm_pkg::LAST_CH_2M;
    endcase
  endfunction

  // Pin sampling; the serial and helper clocks are sampled, not used as clocks
  logic sck_q_r, hck_q_r, tck_q_r;
  logic sck_rise, sck_fall, hck_rise, tck_rise, tck_fall;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sck_q_r <= 1'b0;
      hck_q_r <= 1'b0;
      tck_q_r <= 1'b0;
    end else begin
      sck_q_r <= serial_clock_in;
      hck_q_r <= frame_eval_or_helper_clock_in;
      tck_q_r <= test_clock_in;
    end
  end
  assign sck_rise = serial_clock_in & ~sck_q_r;
  assign sck_fall = ~serial_clock_in & sck_q_r;
  assign hck_rise = frame_eval_or_helper_clock_in & ~hck_q_r;
  assign tck_rise = test_clock_in & ~tck_q_r;
  assign tck_fall = ~test_clock_in & tck_q_r;

  // Reset pin filter: short glitches float outputs but do not clear state
  logic [4:0] low_cnt_r, low_cnt_nxt;
  logic sclr;
  assign sclr = low_cnt_r == tdm_pkg::RESET_CYCLES;
  always_comb begin
    low_cnt_nxt = reset_n_in ? 5'h0 : (sclr ? low_cnt_r : low_cnt_r + 5'h1);
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) low_cnt_r <= 5'h0;
    else low_cnt_r <= low_cnt_nxt;
  end

  // Framing
  tdm_pkg::fmt_t fmt_r, fmt_nxt;
  logic idle_r, idle_nxt, fp_last_r, fp_last_nxt, hprev_r, hprev_nxt, pend_r, pend_nxt;
  logic [2:0] run_r, run_nxt;
  logic std_hit, wfp_hit, start;
  assign std_hit = ~wide_frame_select_in & sck_fall & (fmt_r != tdm_pkg::FMT_UNKNOWN) &
                   (frame_pulse_in == idle_r) & (fp_last_r != idle_r);
  assign wfp_hit = wide_frame_select_in & hck_rise & ~frame_pulse_in & hprev_r;
  assign start = std_hit | (sck_fall & pend_r);
  always_comb begin
    fmt_nxt = fmt_r;
    idle_nxt = idle_r;
    fp_last_nxt = fp_last_r;
    run_nxt = run_r;
    hprev_nxt = hprev_r;
    pend_nxt = pend_r;
    if (wide_frame_select_in) begin
      fmt_nxt = tdm_pkg::FMT_UNKNOWN;
    end else if (sck_fall) begin
      fp_last_nxt = frame_pulse_in;
      if (frame_pulse_in != fp_last_r) run_nxt = 3'h0;
      else if (run_r != tdm_pkg::IDLE_RUN) run_nxt = run_r + 3'h1;
      // Idle level decides the format: high idle is standard, low idle is GCI
      if (run_r == tdm_pkg::IDLE_RUN) begin
        idle_nxt = fp_last_r;
        fmt_nxt = fp_last_r ? tdm_pkg::FMT_STD : tdm_pkg::FMT_GCI;
      end
    end
    if (hck_rise) hprev_nxt = frame_pulse_in;
    if (start) pend_nxt = 1'b0;
    if (wfp_hit) pend_nxt = 1'b1;
    if (sclr) begin
      fmt_nxt = tdm_pkg::FMT_UNKNOWN;
      run_nxt = 3'h0;
      pend_nxt = 1'b0;
    end
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      fmt_r <= tdm_pkg::FMT_UNKNOWN;
      idle_r <= 1'b1;
      fp_last_r <= 1'b1;
      run_r <= 3'h0;
      hprev_r <= 1'b1;
      pend_r <= 1'b0;
    end else begin
      fmt_r <= fmt_nxt;
      idle_r <= idle_nxt;
      fp_last_r <= fp_last_nxt;
      run_r <= run_nxt;
      hprev_r <= hprev_nxt;
      pend_r <= pend_nxt;
    end
  end
  assign frame_format_out = fmt_r;

  // Bit and channel counters; two shift-clock periods per bit
  logic ph_r, ph_nxt, par_r, par_nxt, active_r, active_nxt, fs_r, fs_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [6:0] ch_r, ch_nxt, next_ch;
  logic chan_end, sample;
  assign chan_end = sck_fall & ph_r & (bit_r == tdm_pkg::LAST_BIT) & ~start;
  assign sample = sck_rise & ph_r;
  assign next_ch = (ch_r == last_chan(rate_field_in)) ? 7'h0 : ch_r + 7'h1;
  always_comb begin
    ph_nxt = ph_r;
    bit_nxt = bit_r;
    ch_nxt = ch_r;
    par_nxt = par_r;
    active_nxt = active_r;
    fs_nxt = start;
    if (start) begin
      ph_nxt = 1'b0;
      bit_nxt = 3'h0;
      ch_nxt = 7'h0;
      par_nxt = ~par_r;
      active_nxt = 1'b1;
    end else if (sck_fall) begin
      ph_nxt = ~ph_r;
      if (ph_r) bit_nxt = bit_r + 3'h1;
      if (chan_end) ch_nxt = next_ch;
    end
    if (sclr) begin
      ph_nxt = 1'b0;
      bit_nxt = 3'h0;
      ch_nxt = 7'h0;
      active_nxt = 1'b0;
      fs_nxt = 1'b0;
    end
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ph_r <= 1'b0;
      bit_r <= 3'h0;
      ch_r <= 7'h0;
      par_r <= 1'b0;
      active_r <= 1'b0;
      fs_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      bit_r <= bit_nxt;
      ch_r <= ch_nxt;
      par_r <= par_nxt;
      active_r <= active_nxt;
      fs_r <= fs_nxt;
    end
  end
  assign frame_start_out = fs_r;

  // Input capture; bytes are pushed one per cycle and stall on a full FIFO
  logic [7:0] in_sh_r [16], in_sh_nxt [16], cap_r [16], cap_nxt [16];
  logic [6:0] cap_ch_r, cap_ch_nxt;
  logic cap_par_r, cap_par_nxt, push_busy_r, push_busy_nxt;
  logic [3:0] push_idx_r, push_idx_nxt;
  logic fifo_in_ready, wr_valid, wr_ready;
  tdm_pkg::byte_wr_t push_word, wr_word;
  assign push_word = '{par: cap_par_r, stream: push_idx_r, channel: cap_ch_r,
                       data: cap_r[push_idx_r]};
  always_comb begin
    cap_ch_nxt = cap_ch_r;
    cap_par_nxt = cap_par_r;
    push_busy_nxt = push_busy_r;
    push_idx_nxt = push_idx_r;
    for (int s = 0; s < tdm_pkg::STREAMS; s++) begin
      in_sh_nxt[s] = sample ? {in_sh_r[s][6:0], serial_in_streams_in[s]} : in_sh_r[s];
      cap_nxt[s] = cap_r[s];
    end
    if (push_busy_r & fifo_in_ready) begin
      push_idx_nxt = push_idx_r + 4'h1;
      if (push_idx_r == tdm_pkg::LAST_STREAM) push_busy_nxt = 1'b0;
    end
    if (sample & (bit_r == tdm_pkg::LAST_BIT)) begin
      for (int s = 0; s < tdm_pkg::STREAMS; s++) cap_nxt[s] = in_sh_nxt[s];
      cap_ch_nxt = ch_r;
      cap_par_nxt = par_r;
      push_busy_nxt = 1'b1;
      push_idx_nxt = 4'h0;
    end
    if (sclr) push_busy_nxt = 1'b0;
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      for (int s = 0; s < tdm_pkg::STREAMS; s++) begin
        in_sh_r[s] <= 8'h00;
        cap_r[s] <= 8'h00;
      end
      cap_ch_r <= 7'h0;
      cap_par_r <= 1'b0;
      push_busy_r <= 1'b0;
      push_idx_r <= 4'h0;
    end else begin
      in_sh_r <= in_sh_nxt;
      cap_r <= cap_nxt;
      cap_ch_r <= cap_ch_nxt;
      cap_par_r <= cap_par_nxt;
      push_busy_r <= push_busy_nxt;
      push_idx_r <= push_idx_nxt;
    end
  end

  tdm_fifo #(
    .WIDTH($bits(tdm_pkg::byte_wr_t)),
    .DEPTH(tdm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .in_valid_in(push_busy_r),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_word),
    .out_valid_out(wr_valid),
    .out_ready_in(wr_ready),
    .out_data_out(wr_word)
  );

  // Switching memories; the data store is double buffered by frame parity
  logic [7:0] data_mem [4096];
  logic [10:0] conn_mem [2048];
  logic fetch_busy_r, fetch_busy_nxt;
  assign wr_ready = ~fetch_busy_r; // Single port: fetches win, the FIFO absorbs writes
  always_ff @(posedge clock_in) begin
    if (wr_valid & wr_ready) begin
      data_mem[{wr_word.par, wr_word.stream, wr_word.channel}] <= wr_word.data;
    end
    if (conn_wr_in) begin
      conn_mem[conn_addr_in] <= conn_src_in;
    end
  end

  // Fetch the next channel for all sixteen outputs, then shift it out
  logic [3:0] fetch_idx_r, fetch_idx_nxt;
  logic [7:0] nxt_r [16], nxt_nxt [16], out_sh_r [16], out_sh_nxt [16];
  logic [10:0] src;
  assign src = conn_mem[{fetch_idx_r, next_ch}];
  always_comb begin
    fetch_busy_nxt = fetch_busy_r;
    fetch_idx_nxt = fetch_idx_r;
    for (int s = 0; s < tdm_pkg::STREAMS; s++) begin
      nxt_nxt[s] = nxt_r[s];
      if (chan_end | start) out_sh_nxt[s] = nxt_r[s];
      else if (sck_fall & ph_r) out_sh_nxt[s] = {out_sh_r[s][6:0], 1'b0};
      else out_sh_nxt[s] = out_sh_r[s];
    end
    if (fetch_busy_r) begin
      nxt_nxt[fetch_idx_r] = data_mem[{~par_r, src}];
      fetch_idx_nxt = fetch_idx_r + 4'h1;
      if (fetch_idx_r == tdm_pkg::LAST_STREAM) fetch_busy_nxt = 1'b0;
    end
    if (sck_fall & ph_r & (bit_r == 3'h0) & ~start) begin
      fetch_busy_nxt = 1'b1;
      fetch_idx_nxt = 4'h0;
    end
    if (sclr) fetch_busy_nxt = 1'b0;
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      fetch_busy_r <= 1'b0;
      fetch_idx_r <= 4'h0;
      for (int s = 0; s < tdm_pkg::STREAMS; s++) begin
        nxt_r[s] <= 8'h00;
        out_sh_r[s] <= 8'h00;
      end
    end else begin
      fetch_busy_r <= fetch_busy_nxt;
      fetch_idx_r <= fetch_idx_nxt;
      nxt_r <= nxt_nxt;
      out_sh_r <= out_sh_nxt;
    end
  end
  generate
    for (genvar g = 0; g < 16; g++) begin : g_out
      assign serial_out_streams_out[g] = out_sh_r[g][7];
      assign serial_out_oe_out[g] = reset_n_in & active_r;
    end
  endgenerate

  // Frame offset measurement in half-bit steps
  logic meas_on_r, meas_on_nxt, fe_last_r, fe_last_nxt;
  logic [7:0] meas_cnt_r, meas_cnt_nxt;
  tdm_pkg::offset_t offset_r, offset_nxt;
  always_comb begin
    meas_on_nxt = meas_on_r;
    meas_cnt_nxt = meas_cnt_r;
    fe_last_nxt = fe_last_r;
    offset_nxt = offset_r;
    if (sck_fall) fe_last_nxt = frame_eval_or_helper_clock_in;
    if (start & ~wide_frame_select_in) begin
      meas_on_nxt = 1'b1;
      meas_cnt_nxt = 8'h00;
    end else if (meas_on_r & sck_fall) begin
      if (meas_cnt_r != tdm_pkg::MEAS_MAX) meas_cnt_nxt = meas_cnt_r + 8'h01;
      if (fe_last_r & ~frame_eval_or_helper_clock_in) begin
        offset_nxt = '{valid: 1'b1, stream: eval_stream_in, half_bits: meas_cnt_r};
        meas_on_nxt = 1'b0;
      end
    end
    if (wide_frame_select_in | sclr) meas_on_nxt = 1'b0;
    if (sclr) offset_nxt = '0;
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      meas_on_r <= 1'b0;
      meas_cnt_r <= 8'h00;
      fe_last_r <= 1'b1;
      offset_r <= '0;
    end else begin
      meas_on_r <= meas_on_nxt;
      meas_cnt_r <= meas_cnt_nxt;
      fe_last_r <= fe_last_nxt;
      offset_r <= offset_nxt;
    end
  end
  assign offset_out = offset_r;

  // Test port: one-bit bypass path
  logic byp_r, byp_nxt, tdo_r, tdo_nxt;
  always_comb begin
    byp_nxt = tck_rise ? test_data_in : byp_r;
    tdo_nxt = tck_fall ? byp_r : tdo_r;
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      byp_r <= 1'b0;
      tdo_r <= 1'b0;
    end else begin
      byp_r <= byp_nxt;
      tdo_r <= tdo_nxt;
    end
  end
  assign test_data_out = tdo_r;
  assign test_data_oe_out = scan_enable_in;

  sequence s_fetch_go;
    sck_fall && ph_r && bit_r == 3'h0 && !start && !sclr ##1 fetch_busy_r;
  endsequence
  property p_fetch_span;
    @(posedge clock_in) disable iff (rst_in || sclr)
      s_fetch_go |-> ##15 (fetch_busy_r && fetch_idx_r == 4'hf) ##1 !fetch_busy_r;
  endproperty
  a_fetch_span: assert property (p_fetch_span) else $error("fetch not 16 cycles");
  property p_shift_out;
    @(posedge clock_in) disable iff (rst_in)
      sck_fall && ph_r && !chan_end && !start && !sclr
      |=> serial_out_streams_out[0] == $past(out_sh_r[0][6]);
  endproperty
  a_shift_out: assert property (p_shift_out) else $error("output bit not shifted");
  property p_sample_in;
    @(posedge clock_in) disable iff (rst_in)
      sample |=> in_sh_r[3][0] == $past(serial_in_streams_in[3]);
  endproperty
  a_sample_in: assert property (p_sample_in) else $error("input bit not sampled");
  property p_std_fmt;
    @(posedge clock_in) disable iff (rst_in || sclr)
      !wide_frame_select_in && sck_fall && run_r == tdm_pkg::IDLE_RUN
      |=> fmt_r == ($past(fp_last_r) ? tdm_pkg::FMT_STD : tdm_pkg::FMT_GCI);
  endproperty
  a_std_fmt: assert property (p_std_fmt) else $error("frame format not identified");
  sequence s_wide_edge;
    wide_frame_select_in && hck_rise && !frame_pulse_in && hprev_r;
  endsequence
  property p_wide_pend;
    @(posedge clock_in) disable iff (rst_in || sclr)
      s_wide_edge |=> pend_r;
  endproperty
  a_wide_pend: assert property (p_wide_pend) else $error("wide pulse edge lost");
  property p_eval;
    @(posedge clock_in) disable iff (rst_in || sclr)
      meas_on_r && sck_fall && fe_last_r && !frame_eval_or_helper_clock_in && !start
      |=> offset_out.valid && offset_out.half_bits == $past(meas_cnt_r);
  endproperty
  a_eval: assert property (p_eval) else $error("offset not captured");
  property p_tdo_fall;
    @(posedge clock_in) disable iff (rst_in)
      $changed(test_data_out) |-> $past(tck_fall);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("test data moved off falling edge");
  property p_tdo_float;
    @(posedge clock_in) disable iff (rst_in)
      !scan_enable_in |-> !test_data_oe_out;
  endproperty
  a_tdo_float: assert property (p_tdo_float) else $error("test data driven without scan");
  property p_reset_pin;
    @(posedge clock_in) disable iff (rst_in)
      !reset_n_in && low_cnt_r == tdm_pkg::RESET_CYCLES - 5'h1
      |=> sclr ##1 (!active_r && ch_r == 7'h0 && serial_out_oe_out == 16'h0000);
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin did not clear");
  property p_wrap;
    @(posedge clock_in) disable iff (rst_in || sclr)
      chan_end && ch_r == last_chan(rate_field_in) |=> ch_r == 7'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("channel counter did not wrap");
endmodule

/* test/tdm_far_end.sv */
// Far-end stream source: shift clock, frame pulse, evaluation or helper clock, serial data
`timescale 1ns/100ps
module tdm_far_end (
  input wire logic clock_in,
  input wire logic run_in,
  input wire logic [1:0] rate_in,
  input wire logic wide_in,
  input wire logic gci_in,
  output logic sck_out,
  output logic fp_out,
  output logic fe_out,
  output logic [15:0] sdata_out
);
  // Shift clock scaled to 4 cycles a period, so that the run stays short
  localparam int EVAL_AT = 10;
  int cnt = 0;
  int len;
  int per;
  logic act;
  logic [7:0] b;
  always_comb begin
    len = (rate_in == tdm_pkg::RATE_8M) ? 2048 : (rate_in == tdm_pkg::RATE_4M) ? 1024 : 512;
    per = cnt / 4;
    sck_out = run_in & cnt[1];
    act = wide_in ? (per < 2) : (per == 0);
    fp_out = (gci_in & ~wide_in) ? act : ~act;
    // Helper clock at the 2.048 shift clock rate, scaled like the shift clock
    fe_out = wide_in ? (run_in & cnt[1]) : (per < EVAL_AT);
    for (int s = 0; s < 16; s++) begin
      b = {4'(s), ~4'(s)};
      sdata_out[s] = b[7 - (per / 2) % 8];
    end
  end
  // Clock stands still while stopped
  always @(negedge clock_in) begin
    if (!run_in || cnt >= len * 4 - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

/* test/tb.sv */
// Self-checking bench of the stream timing front end
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t got %0h want %0h", $time, a, b); end end
module tb;
  logic clock_in;
  logic rst_in = 1'b1;
  logic reset_n = 1'b1;
  logic [1:0] rate = 2'h0;
  logic wide = 1'b0;
  logic gci = 1'b0;
  logic run = 1'b0;
  logic tck = 1'b0;
  logic tdi = 1'b0;
  logic tdi_prev = 1'b0;
  logic scan = 1'b0;
  logic conn_wr = 1'b0;
  logic [10:0] caddr = 11'h000;
  logic [10:0] csrc = 11'h000;
  logic [3:0] estr = 4'h0;
  logic [3:0] src;
  logic sck, fp, fe, tdo, tdo_oe, fstart;
  logic [15:0] sin, sout, soe;
  logic [63:0] smp;
  logic [7:0] w;
  logic [31:0] rnd = 32'h0bf5_05ba;
  tdm_pkg::offset_t off;
  tdm_pkg::fmt_t fmt;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int t0, t1;

  tdm_far_end far (.clock_in(clock_in), .run_in(run), .rate_in(rate), .wide_in(wide),
    .gci_in(gci), .sck_out(sck), .fp_out(fp), .fe_out(fe), .sdata_out(sin));
  tdm_stream_frame_timing DUT (.clock_in(clock_in), .rst_in(rst_in), .reset_n_in(reset_n),
    .rate_field_in(rate), .wide_frame_select_in(wide), .serial_clock_in(sck),
    .frame_pulse_in(fp), .frame_eval_or_helper_clock_in(fe), .serial_in_streams_in(sin),
    .serial_out_streams_out(sout), .serial_out_oe_out(soe), .conn_wr_in(conn_wr),
    .conn_addr_in(caddr), .conn_src_in(csrc), .eval_stream_in(estr), .offset_out(off),
    .frame_format_out(fmt), .frame_start_out(fstart), .test_clock_in(tck),
    .test_data_in(tdi), .scan_enable_in(scan), .test_data_out(tdo),
    .test_data_oe_out(tdo_oe));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Channels per frame times 8 bits, 2 shift periods a bit, 4 cycles a period
  function automatic int exp_len(input logic [1:0] r);
    return (r == 2'h2 ? 128 : r == 2'h1 ? 64 : 32) * 8 * 2 * 4;
  endfunction
  // Bit phase of the output is not fixed against the source, so any rotation matches
  function automatic logic rot_hit(input logic [7:0] v, input logic [7:0] p);
    logic h;
    h = 1'b0;
    for (int r = 0; r < 8; r++) h |= (v == ((p << r) | (p >> (8 - r))));
    return h;
  endfunction
  task automatic wait_start(output int t);
    for (int k = 0; k < 10000; k++) begin
      @(negedge clock_in);
      if (fstart === 1'b1) break;
    end
    t = cyc;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    repeat (6) @(negedge clock_in);
    `CHK(fmt, tdm_pkg::FMT_UNKNOWN)
    `CHK(soe, 16'h0000)
    `CHK(fstart, 1'b0)
    rst_in = 1'b0;
    $display("test reset done");
    scan = 1'b1;
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      tdi = rnd[0];
      repeat (2) @(negedge clock_in);
      tck = 1'b1;
      repeat (4) @(negedge clock_in);
      `CHK(tdo, tdi_prev)
      tck = 1'b0;
      repeat (4) @(negedge clock_in);
      `CHK(tdo, tdi)
      `CHK(tdo_oe, 1'b1)
      tdi_prev = tdi;
    end
    scan = 1'b0;
    @(negedge clock_in);
    `CHK(tdo_oe, 1'b0)
    $display("test port done");
    rnd = lfsr(rnd);
    src = rnd[3:0];
    for (int c = 0; c < 128; c++) begin
      caddr = {4'h0, 7'(c)};
      csrc = {src, 7'(c)};
      conn_wr = 1'b1;
      @(negedge clock_in);
      conn_wr = 1'b0;
      @(negedge clock_in);
    end
    run = 1'b1;
    for (int r = 0; r < 4; r++) begin
      rate = 2'(r);
      wait_start(t0);
      wait_start(t1);
      `CHK(t1 - t0, exp_len(rate))
      `CHK(soe, 16'hffff)
      `CHK(fmt, tdm_pkg::FMT_STD)
    end
    $display("test rates done");
    rate = 2'h0;
    repeat (3) wait_start(t0);
    for (int i = 0; i < 64; i++) begin
      @(posedge sck);
      @(negedge clock_in);
      smp[i] = sout[0];
    end
    t0 = 0;
    for (int i = 16; i < 64; i++) t0 += (smp[i] !== smp[i - 16]);
    for (int k = 0; k < 8; k++) w[7 - k] = smp[2 * k + 1];
    `CHK(t0, 0)
    `CHK(rot_hit(w, {src, ~src}), 1'b1)
    $display("test switch done");
    rnd = lfsr(rnd);
    estr = rnd[3:0];
    wait_start(t0);
    repeat (80) @(negedge clock_in);
    `CHK(off.valid, 1'b1)
    `CHK(off.stream, estr)
    `CHK(off.half_bits inside {[8'h08 : 8'h0b]}, 1'b1)
    $display("test offset done");
    gci = 1'b1;
    repeat (3) wait_start(t0);
    `CHK(fmt, tdm_pkg::FMT_GCI)
    reset_n = 1'b0;
    repeat (5) @(negedge clock_in);
    `CHK(soe, 16'h0000)
    reset_n = 1'b1;
    @(negedge clock_in);
    `CHK(fmt, tdm_pkg::FMT_GCI)
    reset_n = 1'b0;
    repeat (25) @(negedge clock_in);
    reset_n = 1'b1;
    @(negedge clock_in);
    `CHK(fmt, tdm_pkg::FMT_UNKNOWN)
    `CHK(soe, 16'h0000)
    repeat (2) wait_start(t0);
    @(negedge clock_in);
    `CHK(soe, 16'hffff)
    $display("test format and reset pin done");
    wide = 1'b1;
    gci = 1'b0;
    repeat (2) wait_start(t0);
    wait_start(t1);
    `CHK(t1 - t0, exp_len(2'h0))
    $display("test wide pulse done");
    final_report();
  end
endmodule
